// ---- verilog/safety_sensor_diag_encoder.sv ----
// diagnostic status encoder: leds, fault bit, safety code and parameter reply
`timescale 1ns/1ps
// Overview of operation
// RQ1 - guard open: green only, fault clear, code 0; closed: yellow, dynamic code
// RQ2 - limit area: duo alternates, yellow flashes, fault set, dynamic code kept
// RQ3 - enabling inhibit: duo alternates, red and yellow off, fault set, code 0
// RQ4 - device or periphery error: duo alternates, red flash code, fault, code 0
// RQ5 - address zero or bus failure: duo steady red, fault clear, code 0
// RQ6 - red shows 4 pulses hot, 5 actuator fault, steady for defect
// RQ7 - temperature above seventy degrees is the over-temperature error
// RQ8 - wrong or defective actuator is the actuator error, immediate switch-off
// RQ9 - every recognised error also raises the periphery fault bit; the code leaves it clear while teach-in or a bus error is shown
// RQ10 - fault bit set always means alternating red-green duo led
// RQ11 - master reads parameter bits by writing parameter value F
// RQ12 - parameter write reply carries current diagnostic parameter bits
// RQ13 - diagnostic bits: present, hysteresis, inhibit, error
// RQ14 - detection variant returns actuator number 1 to 15
// RQ15 - detection variant returns zero without an actuator
// RQ16 - ten minute inhibit after teaching, restarted by power loss; reset here ends the inhibit instead
// RQ17 - error indication clears only after guard opened and closed again
// RQ18 - teach-in: red on, yellow 1 Hz, after ten seconds 3 Hz
// RQ19 - priority: bus error, error, inhibit, limit area, guard state; the code also ranks teach-in between bus error and error
// RQ20 - flash patterns come from a free-running divided time base
module safety_sensor_diag_encoder #(
  parameter longint unsigned INHIBIT_CYCLES = sensor_diag_pkg::INHIBIT_CYC,
  parameter longint unsigned TEACH_CYCLES = sensor_diag_pkg::TEACH_CYC,
  parameter longint unsigned TICK_CYCLES = sensor_diag_pkg::FLASH_TICK_CYC
) (
  // clock, reset, enable
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // sensed device state
  input wire logic guardClosed,
  input wire logic limitArea,
  input wire logic actuatorPresent,
  input wire logic [3:0] actuatorId,
  input wire logic [7:0] tempCelsius,
  input wire logic actuatorFault,
  input wire logic internalDefect,
  input wire logic teachActive,
  input wire logic teachDone,
  // slave interface state
  input wire logic [4:0] slaveAddr,
  input wire logic commError,
  input wire logic [3:0] dynCode,
  input wire logic paramWrStb,
  input wire logic [3:0] paramWrData,
  // indications and replies
  output sensor_diag_pkg::led_s leds,
  output logic periphery_fault_bit,
  output logic [3:0] safety_data_code,
  output logic [3:0] paramReply,
  output logic paramReplyValid
);

  // ==================================================
  // declarations
  logic [31:0] ctrl;
  sensor_diag_pkg::mode_e mode;
  sensor_diag_pkg::mode_e next_mode;
  sensor_diag_pkg::pattern_s pat;
  logic [2:0] pulses;
  logic [2:0] next_pulses;
  logic errLatched;
  logic sawOpen;
  logic [2:0] errPulses;
  logic [39:0] inhibitCnt;
  logic inhibitActive;
  logic [35:0] teachCnt;
  logic teachLate;
  logic overTemp;
  logic errNow;
  logic busErr;
  logic errClear;
  logic inhibitDone;
  logic variantAd;
  logic [3:0] paramBits;
  logic [3:0] diagBits;
  logic [3:0] adBits;
  sensor_diag_pkg::led_s next_leds;
  logic next_fault;
  logic [3:0] next_code;
  logic apbAccess;
  logic apbWr;
  logic apbHit;
  logic [31:0] next_prdata;
  logic [31:0] statusWord;

  // ==================================================
  // time base for flashing
  led_pattern_gen #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_pattern (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .ce(ce),
    .pulses(pulses),
    .pat(pat)
  );

  // ==================================================
  // error detection
  assign overTemp = tempCelsius > sensor_diag_pkg::TEMP_LIMIT_C; // RQ7
  assign errNow = overTemp || actuatorFault || internalDefect; // RQ8
  assign busErr = (slaveAddr == 5'd0) || commError; // RQ5
  // reset needs a full open-close cycle with the cause gone
  assign errClear = !errNow && sawOpen && guardClosed; // RQ17
  // steady red wins over pulse codes, a defect hides the others
  assign next_pulses = internalDefect ? sensor_diag_pkg::PULSES_STEADY :
                       actuatorFault ? sensor_diag_pkg::PULSES_ACTUATOR :
                       overTemp ? sensor_diag_pkg::PULSES_TEMP : errPulses; // RQ6

  // latched error and guard cycle tracking, a fresh error wins over clearing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      errLatched <= 1'b0;
      sawOpen <= 1'b0;
      errPulses <= sensor_diag_pkg::PULSES_STEADY;
    end else if (ce) begin
      errLatched <= errNow || (errLatched && !errClear); // RQ17
      sawOpen <= errLatched && !errNow && (sawOpen || !guardClosed);
      errPulses <= next_pulses;
    end
  end

  // ==================================================
  // enabling inhibit after teaching; power loss is a reset, which ends it and reloads the count
  assign inhibitDone = (inhibitCnt == 40'd0);

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      inhibitCnt <= 40'(INHIBIT_CYCLES); // RQ16
      inhibitActive <= 1'b0;
    end else if (ce) begin
      if (teachDone) begin
        inhibitCnt <= 40'(INHIBIT_CYCLES); // RQ16
        inhibitActive <= 1'b1;
      end else if (inhibitActive) begin
        inhibitCnt <= inhibitDone ? inhibitCnt : inhibitCnt - 40'd1;
        // ends only once time is up and the new actuator is seen
        inhibitActive <= !(inhibitDone && actuatorPresent); // RQ16
      end
    end
  end

  // teach-in duration, drives the change to the fast flash
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      teachCnt <= '0;
      teachLate <= 1'b0;
    end else if (ce) begin
      teachCnt <= (teachActive && !teachLate) ? teachCnt + 36'd1 : (teachActive ? teachCnt : '0);
      teachLate <= teachActive && (teachLate || teachCnt == 36'(TEACH_CYCLES - 64'd1)); // RQ18
    end
  end

  // ==================================================
  // mode selection by priority
  assign next_mode = busErr ? sensor_diag_pkg::MODE_BUSERR :
                     teachActive ? sensor_diag_pkg::MODE_TEACH :
                     (errNow || errLatched) ? sensor_diag_pkg::MODE_ERROR :
                     inhibitActive ? sensor_diag_pkg::MODE_INHIBIT :
                     limitArea ? sensor_diag_pkg::MODE_LIMIT :
                     guardClosed ? sensor_diag_pkg::MODE_CLOSED : sensor_diag_pkg::MODE_OPEN; // RQ19

  // output decode for the chosen mode
  always_comb begin
    next_leds = '0;
    next_fault = 1'b0;
    next_code = sensor_diag_pkg::SAFE_CODE_OFF;
    case (next_mode)
      sensor_diag_pkg::MODE_OPEN: begin
        next_leds.duoGreen = 1'b1; // RQ1
      end
      sensor_diag_pkg::MODE_CLOSED: begin
        next_leds.duoGreen = 1'b1;
        next_leds.yellow = 1'b1; // RQ1
        next_code = dynCode;
      end
      sensor_diag_pkg::MODE_LIMIT: begin
        next_leds.duoGreen = pat.alt;
        next_leds.duoRed = !pat.alt;
        next_leds.yellow = pat.y3; // RQ2
        next_fault = 1'b1;
        next_code = dynCode;
      end
      sensor_diag_pkg::MODE_INHIBIT: begin
        next_leds.duoGreen = pat.alt; // RQ3
        next_leds.duoRed = !pat.alt;
        next_fault = 1'b1;
      end
      sensor_diag_pkg::MODE_ERROR: begin
        next_leds.duoGreen = pat.alt; // RQ10
        next_leds.duoRed = !pat.alt;
        next_leds.red = pat.red; // RQ4
        next_fault = 1'b1; // RQ9
      end
      sensor_diag_pkg::MODE_TEACH: begin
        next_leds.duoGreen = 1'b1;
        next_leds.red = 1'b1;
        next_leds.yellow = teachLate ? pat.y3 : pat.y1; // RQ18
      end
      sensor_diag_pkg::MODE_BUSERR: begin
        next_leds.duoRed = 1'b1; // RQ5
      end
      default: begin
        next_leds = '0;
      end
    endcase
  end

  // indications registered together so they never disagree
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mode <= sensor_diag_pkg::MODE_OPEN;
      leds <= '0;
      periphery_fault_bit <= 1'b0;
      safety_data_code <= sensor_diag_pkg::SAFE_CODE_OFF;
      pulses <= sensor_diag_pkg::PULSES_STEADY;
    end else if (ce) begin
      mode <= next_mode;
      leds <= next_leds;
      periphery_fault_bit <= next_fault; // RQ9
      safety_data_code <= next_code; // RQ1
      pulses <= next_pulses;
    end
  end

  // ==================================================
  // parameter port reply
  assign variantAd = ctrl[sensor_diag_pkg::CTRL_VARIANT_BIT];
  assign diagBits = {errNow || errLatched, inhibitActive, limitArea, actuatorPresent}; // RQ13
  assign adBits = actuatorPresent ? actuatorId : 4'h0; // RQ15
  assign paramBits = variantAd ? adBits : diagBits; // RQ14

  // every parameter write is answered; the master chooses F to read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      paramReply <= 4'h0;
      paramReplyValid <= 1'b0;
    end else if (ce) begin
      paramReplyValid <= paramWrStb; // RQ12
      paramReply <= paramWrStb ? paramBits : paramReply; // RQ12
    end
  end

  // ==================================================
  // apb slave: one wait state, answer registered
  assign apbAccess = psel && penable && !pready;
  assign apbWr = apbAccess && pwrite && (paddr == sensor_diag_pkg::CTRL_OFS);
  assign statusWord = {19'h0, errPulses, 1'b0, inhibitActive && inhibitDone, 1'b0,
                       periphery_fault_bit, inhibitActive, errLatched, 1'b0, mode};
  assign apbHit = (paddr == sensor_diag_pkg::CTRL_OFS) || (paddr == sensor_diag_pkg::STATUS_OFS) ||
                  (paddr == sensor_diag_pkg::PARAM_OFS) || (paddr == sensor_diag_pkg::ACTID_OFS);
  assign next_prdata = (pwrite || !apbHit) ? 32'h0 :
                       (paddr == sensor_diag_pkg::CTRL_OFS) ? ctrl :
                       (paddr == sensor_diag_pkg::STATUS_OFS) ? statusWord :
                       (paddr == sensor_diag_pkg::PARAM_OFS) ? {28'h0, paramBits} :
                       {27'h0, actuatorPresent, actuatorId};

  // writes to read-only words are ignored and flagged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl <= sensor_diag_pkg::CTRL_RESET;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (ce) begin
      pready <= apbAccess;
      pslverr <= apbAccess && (!apbHit || (pwrite && paddr != sensor_diag_pkg::CTRL_OFS));
      prdata <= apbAccess ? next_prdata : prdata;
      ctrl <= apbWr ? {31'h0, pwdata[0]} : ctrl;
    end
  end

  // ==================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  // mode resets to open while the leds reset dark, so the first edge after release is skipped
  guard_open_a: assert property ( // RQ1
    $past(arst_n) && mode == sensor_diag_pkg::MODE_OPEN |-> leds.duoGreen && !leds.red && !leds.yellow
      && !periphery_fault_bit && safety_data_code == 4'h0)
    else $error("guard open indication wrong");
  limit_area_a: assert property ( // RQ2
    mode == sensor_diag_pkg::MODE_LIMIT |-> periphery_fault_bit && !leds.red && leds.duoRed != leds.duoGreen)
    else $error("limit area indication wrong");
  inhibit_show_a: assert property ( // RQ3
    mode == sensor_diag_pkg::MODE_INHIBIT |-> !leds.red && !leds.yellow && safety_data_code == 4'h0)
    else $error("inhibit indication wrong");
  error_show_a: assert property ( // RQ4
    mode == sensor_diag_pkg::MODE_ERROR |-> !leds.yellow && periphery_fault_bit && safety_data_code == 4'h0)
    else $error("error indication wrong");
  bus_error_a: assert property ( // RQ5
    ce && busErr |=> leds.duoRed && !leds.duoGreen && !periphery_fault_bit && safety_data_code == 4'h0)
    else $error("bus error indication wrong");
  fault_duo_a: assert property ( // RQ10
    periphery_fault_bit |-> leds.duoRed != leds.duoGreen)
    else $error("fault without alternating duo led");
  param_reply_a: assert property ( // RQ12
    ce && paramWrStb |=> paramReplyValid && paramReply == $past(paramBits))
    else $error("parameter reply missing");
  error_hold_a: assert property ( // RQ17
    ce && errLatched && !sawOpen |=> errLatched)
    else $error("error cleared without guard cycle");
  hot_error_a: assert property ( // RQ7
    ce && tempCelsius > 8'd70 |=> errLatched)
    else $error("over-temperature not latched");

  limit_seen_c: cover property (mode == sensor_diag_pkg::MODE_LIMIT);
  error_cleared_c: cover property (errLatched ##1 !errLatched);
  reply_seen_c: cover property (paramReplyValid && variantAd);
  teach_fast_c: cover property (mode == sensor_diag_pkg::MODE_TEACH && teachLate);
  bus_error_c: cover property (mode == sensor_diag_pkg::MODE_BUSERR && errLatched);

endmodule

// ---- verilog/sensor_diag_pkg.sv ----
// shared constants and carrier types of the diagnostic encoder
package sensor_diag_pkg;

  // ==================================================
  // apb register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] PARAM_OFS = 8'h08;
  localparam logic [7:0] ACTID_OFS = 8'h0C;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam int CTRL_VARIANT_BIT = 0;

  // ==================================================
  // status register fields
  localparam int ST_MODE_LSB = 0;
  localparam int ST_ERR_BIT = 4;
  localparam int ST_INHIBIT_BIT = 5;
  localparam int ST_FAULT_BIT = 6;
  localparam int ST_SAWOPEN_BIT = 7;
  localparam int ST_ERRCODE_LSB = 8;

  // ==================================================
  // figures and derived cycle counts
  localparam longint unsigned CLK_HZ = 100_000_000;
  localparam longint unsigned INHIBIT_MIN = 10;
  localparam longint unsigned INHIBIT_CYC = INHIBIT_MIN * 64'd60 * CLK_HZ;
  localparam longint unsigned TEACH_S = 10;
  localparam longint unsigned TEACH_CYC = TEACH_S * CLK_HZ;
  localparam longint unsigned FLASH_TICK_US = 166_666;
  localparam longint unsigned FLASH_TICK_CYC = FLASH_TICK_US * CLK_HZ / 64'd1_000_000;
  localparam logic [7:0] TEMP_LIMIT_C = 8'd70;
  localparam logic [2:0] PULSES_TEMP = 3'd4;
  localparam logic [2:0] PULSES_ACTUATOR = 3'd5;
  localparam logic [2:0] PULSES_STEADY = 3'd0;
  localparam logic [3:0] SAFE_CODE_OFF = 4'h0;

  // ==================================================
  // display mode, highest priority last
  typedef enum logic [2:0] {
    MODE_OPEN = 3'b000,
    MODE_CLOSED = 3'b001,
    MODE_LIMIT = 3'b010,
    MODE_INHIBIT = 3'b011,
    MODE_ERROR = 3'b100,
    MODE_TEACH = 3'b101,
    MODE_BUSERR = 3'b110
  } mode_e;

  typedef struct packed {
    logic duoGreen;
    logic duoRed;
    logic red;
    logic yellow;
  } led_s;

  typedef struct packed {
    logic alt;
    logic red;
    logic y1;
    logic y3;
  } pattern_s;

endpackage

// ---- verilog/led_pattern_gen.sv ----
// free-running time base producing the led flash patterns
`timescale 1ns/1ps
module led_pattern_gen #(
  parameter longint unsigned TICK_CYCLES = sensor_diag_pkg::FLASH_TICK_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic ce,
  // pulse group length, zero for steady light
  input wire logic [2:0] pulses,
  // registered patterns
  output sensor_diag_pkg::pattern_s pat
);

  // ==================================================
  // prescaler and slot counters
  logic [35:0] pre;
  logic [3:0] slot;
  logic [1:0] div3;
  logic tick;
  logic groupOn;
  sensor_diag_pkg::pattern_s next_pat;

  assign tick = (pre == 36'(TICK_CYCLES - 64'd1));
  // pulse k lit in slot 2k, slots 2*pulses..15 form the pause between groups
  assign groupOn = (slot[0] == 1'b0) && (slot[3:1] < pulses); // RQ20
  assign next_pat.y3 = tick ? ~pat.y3 : pat.y3;
  assign next_pat.y1 = (tick && div3 == 2'd2) ? ~pat.y1 : pat.y1;
  assign next_pat.alt = next_pat.y1;
  assign next_pat.red = (pulses == sensor_diag_pkg::PULSES_STEADY) ? 1'b1 : groupOn; // RQ6

  // time base stops only while ce is low, so patterns stay in phase with each other
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
      slot <= '0;
      div3 <= '0;
      pat <= '0;
    end else if (ce) begin
      pre <= tick ? '0 : pre + 36'd1; // RQ20
      slot <= tick ? slot + 4'd1 : slot;
      div3 <= tick ? ((div3 == 2'd2) ? 2'd0 : div3 + 2'd1) : div3;
      pat <= next_pat;
    end
  end

endmodule

// ---- tb/fieldbus_master_model.sv ----
// fieldbus master model that polls the slave parameter port
`timescale 1ns/1ps
module fieldbus_master_model (
  // clock
  input wire logic core_clk,
  // parameter port
  output logic paramWrStb,
  output logic [3:0] paramWrData,
  input wire logic [3:0] paramReply,
  input wire logic paramReplyValid
);
  // ==================================================
  // idle bus: strobe low, data not left at the last value
  initial begin
    paramWrStb = 1'b0;
    paramWrData = 4'h0;
  end

  // one parameter write, then a bounded wait for the reply pulse
  task automatic poll(output logic [3:0] reply, output logic ok);
    int n;
    ok = 1'b0;
    reply = 4'h0;
    @(posedge core_clk);
    paramWrStb <= 1'b1;
    paramWrData <= 4'hF;
    @(posedge core_clk);
    paramWrStb <= 1'b0;
    paramWrData <= 4'h0;
    for (n = 0; n < 8 && !ok; n++) begin
      @(posedge core_clk);
      if (paramReplyValid === 1'b1) begin
        reply = paramReply;
        ok = 1'b1;
      end
    end
  endtask
endmodule

// ---- tb/safety_sensor_diag_encoder_bench.sv ----
// self-checking bench of the diagnostic status encoder
`timescale 1ns/1ps
module safety_sensor_diag_encoder_bench;
  // ==================================================
  // clock, reset and design signals
  logic core_clk = 1'b0;
  logic arst_n, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, tempCelsius;
  logic [31:0] pwdata, prdata;
  logic guardClosed, limitArea, actuatorPresent, actuatorFault, internalDefect;
  logic teachActive, teachDone, commError, paramWrStb, paramReplyValid, periphery_fault_bit;
  logic [3:0] actuatorId, dynCode, paramWrData, safety_data_code, paramReply;
  logic [4:0] slaveAddr;
  sensor_diag_pkg::led_s leds;
  int errors = 0;
  int checks_done = 0;
  int rise [4];
  logic both;

  // 100 MHz clock
  always #5 core_clk = ~core_clk;

  // short counts keep the run small
  safety_sensor_diag_encoder #(.INHIBIT_CYCLES(50), .TEACH_CYCLES(40), .TICK_CYCLES(4)) uut (
    .core_clk(core_clk), .arst_n(arst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .guardClosed(guardClosed), .limitArea(limitArea), .actuatorPresent(actuatorPresent),
    .actuatorId(actuatorId), .tempCelsius(tempCelsius), .actuatorFault(actuatorFault),
    .internalDefect(internalDefect), .teachActive(teachActive), .teachDone(teachDone),
    .slaveAddr(slaveAddr), .commError(commError), .dynCode(dynCode), .paramWrStb(paramWrStb),
    .paramWrData(paramWrData), .leds(leds), .periphery_fault_bit(periphery_fault_bit),
    .safety_data_code(safety_data_code), .paramReply(paramReply), .paramReplyValid(paramReplyValid));

  // far side of the parameter port
  fieldbus_master_model bm (.core_clk(core_clk), .paramWrStb(paramWrStb), .paramWrData(paramWrData),
    .paramReply(paramReply), .paramReplyValid(paramReplyValid));

  // ==================================================
  // verdict and comparison
  task stop_test;
    if (errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // apb transfer; a missing pready is cut short by the bound
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      errors++;
      stop_test();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // steady indications: leds, fault bit, safety code
  task ind(input logic [3:0] l, input logic f, input logic [3:0] c);
    check({28'h0, leds}, {28'h0, l});
    check({31'h0, periphery_fault_bit}, {31'h0, f});
    check({28'h0, safety_data_code}, {28'h0, c});
  endtask

  // rising edges of each led over one full 16-tick flash group
  task watch;
    logic [3:0] prev;
    prev = leds;
    both = 1'b0;
    rise = '{default: 0};
    repeat (64) begin
      @(posedge core_clk);
      for (int i = 0; i < 4; i++) if (leds[i] && !prev[i]) rise[i]++;
      if (leds.duoGreen && leds.duoRed) both = 1'b1;
      prev = leds;
    end
  endtask

  task automatic pp(input logic [3:0] exp);
    logic [3:0] r;
    logic ok;
    bm.poll(r, ok);
    check({31'h0, ok}, 32'h1);
    check({28'h0, r}, {28'h0, exp});
  endtask

  // error indication clears only after the guard opens and closes
  task reguard;
    guardClosed <= 1'b0;
    wt(4);
    guardClosed <= 1'b1;
    wt(4);
  endtask

  // ==================================================
  // hang guard
  initial begin
    wt(60000);
    errors++;
    stop_test();
  end

  // main sequence
  initial begin
    logic [31:0] rd;
    logic err;
    arst_n = 0; ce = 1; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
    guardClosed = 0; limitArea = 0; actuatorPresent = 1; actuatorId = 4'h9; tempCelsius = 8'd25;
    actuatorFault = 0; internalDefect = 0; teachActive = 0; teachDone = 0;
    slaveAddr = 5'h05; commError = 0; dynCode = 4'hA;
    wt(20);
    arst_n <= 1'b1;
    apb(0, sensor_diag_pkg::CTRL_OFS, 0, rd, err);
    check(rd, sensor_diag_pkg::CTRL_RESET);
    apb(0, 8'h10, 0, rd, err);
    check({31'h0, err}, 32'h1);
    apb(1, sensor_diag_pkg::STATUS_OFS, 32'hF, rd, err);
    check({31'h0, err}, 32'h1);
    wt(4);
    ind(4'b1000, 0, 4'h0);
    pp(4'b0001);
    guardClosed <= 1; wt(4);
    ind(4'b1001, 0, 4'hA);
    apb(0, sensor_diag_pkg::STATUS_OFS, 0, rd, err);
    check({29'h0, rd[2:0]}, 32'h1);
    limitArea <= 1; wt(4);
    check({31'h0, periphery_fault_bit}, 32'h1);
    check({28'h0, safety_data_code}, 32'hA);
    watch;
    check(rise[3] > 0 && rise[2] > 0 && !both && rise[0] > 0 && rise[1] == 0, 1);
    pp(4'b0011);
    limitArea <= 0; tempCelsius <= 8'd70; wt(4);
    ind(4'b1001, 0, 4'hA);
    tempCelsius <= 8'd71; wt(4);
    check({31'h0, periphery_fault_bit}, 32'h1);
    check({28'h0, safety_data_code}, 32'h0);
    watch;
    check(rise[1], 4);
    check(rise[3] > 0 && rise[2] > 0 && !both && rise[0] == 0 && !leds.yellow, 1);
    pp(4'b1001);
    tempCelsius <= 8'd25; wt(4);
    check({31'h0, periphery_fault_bit}, 32'h1);
    reguard;
    ind(4'b1001, 0, 4'hA);
    actuatorFault <= 1; wt(4);
    check({28'h0, safety_data_code}, 32'h0);
    watch;
    check(rise[1], 5);
    actuatorFault <= 0; reguard;
    internalDefect <= 1; wt(4);
    watch;
    check({31'h0, leds.red}, 32'h1);
    check(rise[1], 0);
    // one assignment per signal and step: address zero first, then a link failure
    for (int i = 0; i < 2; i++) begin
      slaveAddr <= (i == 0) ? 5'h00 : 5'h05;
      commError <= (i == 1);
      wt(4);
      check({30'h0, leds[3:2]}, 32'h1);
      check({31'h0, periphery_fault_bit}, 32'h0);
      check({28'h0, safety_data_code}, 32'h0);
    end
    slaveAddr <= 5'h05;
    commError <= 1'b0;
    internalDefect <= 0; reguard;
    actuatorPresent <= 0; teachDone <= 1; wt(1);
    teachDone <= 0; wt(60);
    check({31'h0, periphery_fault_bit}, 32'h1);
    check({28'h0, safety_data_code}, 32'h0);
    check({30'h0, leds[1:0]}, 32'h0);
    pp(4'b0100);
    actuatorPresent <= 1; wt(4);
    ind(4'b1001, 0, 4'hA);
    apb(1, sensor_diag_pkg::CTRL_OFS, 32'h1, rd, err);
    apb(0, sensor_diag_pkg::CTRL_OFS, 0, rd, err);
    check(rd, 32'h1);
    pp(4'h9);
    actuatorId <= 4'hF; wt(2);
    pp(4'hF);
    actuatorPresent <= 0; wt(2);
    pp(4'h0);
    teachActive <= 1; wt(4);
    check({31'h0, leds.red}, 32'h1);
    // past the shortened teach time the yellow led runs at the fast rate
    wt(40);
    watch;
    check(rise[0], 8);
    // clock enable low freezes the indications
    ce <= 1'b0;
    teachActive <= 1'b0;
    wt(4);
    check({31'h0, leds.red}, 32'h1);
    ce <= 1'b1;
    wt(4);
    ind(4'b1001, 0, 4'hA);
    stop_test();
  end
endmodule
